// file: design/bwm_top.sv
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "bwm_params.svh"
module bwm_top import bwm_pkg::*; #(
    parameter int MS_CYC = `BWM_MS_NS / `BWM_CLK_NS,
    parameter int MS_PER_S = `BWM_MS_PER_S,
    parameter int WIN_S = `BWM_WIN_MIN * 60,
    parameter int DEPTH = `BWM_TRIP_MAX,
    parameter int TS_W = 12
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] cur_a,
    input wire logic [15:0] cur_b,
    input wire logic [15:0] cur_c,
    input wire logic [2:0] meas_ok,
    input wire logic trip_cmd,
    input wire logic man_open_cmd,
    input wire logic open_fail,
    input wire logic brk_open,
    input wire logic manual_close_cmd,
    input wire logic wear_sum_clear_cmd,
    input wire logic wear_sum_load_cmd,
    input wire logic [2:0] wear_sum_load_sel,
    input wire logic [31:0] wear_sum_load_value,
    output logic wear_sum_alarm,
    output logic wear_sum_alarm_evt,
    output logic wear_sum_clear_evt,
    output logic excessive_trip_count_flag,
    output logic reclose_lockout,
    output logic irq
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
    localparam logic [TS_W-1:0] WIN_C = TS_W'(WIN_S);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DEPTH < `BWM_TRIP_MAX || DEPTH > 127) begin : g_chk_depth
        $error("DEPTH must hold 100 to 127 openings");
    end
    if ((1 << TS_W) <= 2 * WIN_S || MS_CYC < 2 || MS_PER_S < 2) begin : g_chk_time
        $error("Timestamp width or tick counts too small");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[32] ? 32'hffffffff : s[31:0];
    endfunction

    // Wear increment in 0.01 kA^2s; fractions below one step are dropped
    function automatic logic [31:0] wear_term(input logic [15:0] c, input logic [15:0] r,
                                              input logic [15:0] t);
        logic [79:0] p;
        logic [79:0] w;
        p = {64'h0, c} * {64'h0, r};
        w = p * p;
        w = w * {64'h0, t};
        w = w / `BWM_TERM_DIV;
        return (w > 80'h00000000ffffffff) ? 32'hffffffff : w[31:0];
    endfunction

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    logic [23:0] ms_cnt_r;
    logic [15:0] sec_cnt_r;
    logic [TS_W-1:0] now_r;
    logic ms_tick;
    logic sec_tick;
    assign ms_tick = ms_cnt_r == 24'(MS_CYC - 1);
    assign sec_tick = ms_tick && sec_cnt_r == 16'(MS_PER_S - 1);

    // Millisecond and second counters; seconds wrap, ages use modulo math
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ms_cnt_r <= '0;
            sec_cnt_r <= '0;
            now_r <= '0;
        end else if (ce) begin
            ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 24'h1;
            if (ms_tick) begin
                sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + 16'h1;
            end
            if (sec_tick) begin
                now_r <= now_r + TS_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Register file and Avalon slave
    // ------------------------------------------------------------
    logic ack_r;
    logic [6:0] thr_r;
    logic [`BWM_ST_W-1:0] st_r;
    logic [`BWM_ST_W-1:0] mask_r;
    logic [`BWM_ST_W-1:0] ev;
    logic [23:0] alarm_lvl_r;
    logic [23:0] drop_lvl_r;
    logic [15:0] ratio_r;
    logic [15:0] inom_r;
    logic [31:0] acc_r [3];
    bwm_cur_t cap_r [3];
    logic [PW:0] cnt_r;
    logic wr_go;
    logic rd_go;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign wr_go = avs_write && ack_r && ce;
    assign rd_go = avs_read && !ack_r && ce;

    // One wait cycle per access; read data is loaded during it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else if (ce) begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    // Read mux; unmapped offsets read zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= '0;
        end else if (rd_go) begin
            unique case (avs_address)
                `BWM_REG_CTRL: avs_readdata <= {25'h0, thr_r};
                `BWM_REG_STATUS: avs_readdata <= {27'h0, st_r};
                `BWM_REG_MASK: avs_readdata <= {27'h0, mask_r};
                `BWM_REG_ALARM: avs_readdata <= {8'h0, alarm_lvl_r};
                `BWM_REG_DROP: avs_readdata <= {8'h0, drop_lvl_r};
                `BWM_REG_RATIO: avs_readdata <= {16'h0, ratio_r};
                `BWM_REG_INOM: avs_readdata <= {16'h0, inom_r};
                `BWM_REG_OPCNT: avs_readdata <= 32'(cnt_r);
                `BWM_REG_ACC0: avs_readdata <= acc_r[0];
                `BWM_REG_ACC0 + 8'h4: avs_readdata <= acc_r[1];
                `BWM_REG_ACC0 + 8'h8: avs_readdata <= acc_r[2];
                `BWM_REG_CAP0: avs_readdata <= {16'h0, cap_r[0]};
                `BWM_REG_CAP0 + 8'h4: avs_readdata <= {16'h0, cap_r[1]};
                `BWM_REG_CAP0 + 8'h8: avs_readdata <= {16'h0, cap_r[2]};
                default: avs_readdata <= '0;
            endcase
        end
    end

    // Settings; out-of-range values are ignored rather than clamped
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            thr_r <= `BWM_THR_RST;
            mask_r <= '0;
            alarm_lvl_r <= `BWM_ALARM_RST;
            drop_lvl_r <= `BWM_DROP_RST;
            ratio_r <= `BWM_RATIO_RST;
            inom_r <= `BWM_INOM_RST;
        end else if (wr_go) begin
            if (avs_address == `BWM_REG_CTRL && avs_writedata[6:0] != 7'h0
                && avs_writedata[6:0] <= `BWM_THR_MAX && avs_writedata[31:7] == '0) begin
                thr_r <= avs_writedata[6:0]; // see RL10
            end
            if (avs_address == `BWM_REG_MASK) begin
                mask_r <= avs_writedata[`BWM_ST_W-1:0];
            end
            if (avs_address == `BWM_REG_ALARM && avs_writedata <= {8'h0, `BWM_LVL_MAX}) begin
                alarm_lvl_r <= avs_writedata[23:0]; // see RL13
            end
            if (avs_address == `BWM_REG_DROP && avs_writedata <= {8'h0, `BWM_LVL_MAX}) begin
                drop_lvl_r <= avs_writedata[23:0]; // see RL13
            end
            if (avs_address == `BWM_REG_RATIO) begin
                ratio_r <= avs_writedata[15:0];
            end
            if (avs_address == `BWM_REG_INOM) begin
                inom_r <= avs_writedata[15:0];
            end
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else if (ce) begin
            if (wr_go && avs_address == `BWM_REG_STATUS) begin
                st_r <= (st_r & ~avs_writedata[`BWM_ST_W-1:0]) | ev;
            end else begin
                st_r <= st_r | ev;
            end
        end
    end
    assign irq = |(st_r & mask_r);

    // ------------------------------------------------------------
    // Opening capture
    // ------------------------------------------------------------
    bwm_cap_t st_cap_r;
    bwm_cur_t cur [3];
    bwm_cur_t peak_r [3];
    logic brk_q_r;
    logic man_r;
    logic [15:0] opn_ms_r;
    logic [15:0] time_r;
    logic [15:0] ratio_s_r;
    logic add_r;
    logic open_rise;
    logic cmd;
    assign cur[0] = cur_a;
    assign cur[1] = cur_b;
    assign cur[2] = cur_c;
    assign open_rise = brk_open && !brk_q_r;
    assign cmd = trip_cmd || man_open_cmd;

    // Tracks command-to-open peak; samples all operands at the open edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_cap_r <= BWM_IDLE;
            brk_q_r <= 1'b0;
            man_r <= 1'b0;
            opn_ms_r <= '0;
            time_r <= '0;
            ratio_s_r <= '0;
            add_r <= 1'b0;
            for (int p = 0; p < 3; p++) begin
                peak_r[p] <= '0;
                cap_r[p] <= '0;
            end
        end else if (ce) begin
            brk_q_r <= brk_open;
            add_r <= 1'b0;
            if (open_rise) begin
                for (int p = 0; p < 3; p++) begin
                    if (!meas_ok[p]) begin
                        cap_r[p] <= inom_r; // see RL3
                    end else if (st_cap_r == BWM_TRACK && peak_r[p] > cur[p]) begin
                        cap_r[p] <= peak_r[p]; // see RL1
                    end else begin
                        cap_r[p] <= cur[p]; // see RL3
                    end
                end
                // Fixed time when not relay-tripped or when manual
                time_r <= (st_cap_r == BWM_TRACK && !man_r) ? opn_ms_r : 16'(`BWM_MAN_MS); // see RL6
                ratio_s_r <= ratio_r; // see RL5
                add_r <= 1'b1; // see RL4
                st_cap_r <= BWM_IDLE;
            end else if (cmd) begin
                st_cap_r <= BWM_TRACK; // see RL2
                man_r <= man_open_cmd && !trip_cmd;
                opn_ms_r <= '0;
                for (int p = 0; p < 3; p++) begin
                    peak_r[p] <= cur[p];
                end
            end else if (st_cap_r == BWM_TRACK && open_fail) begin
                st_cap_r <= BWM_IDLE;
                for (int p = 0; p < 3; p++) begin
                    cap_r[p] <= '0; // see RL2
                end
            end else if (st_cap_r == BWM_TRACK) begin
                if (ms_tick && opn_ms_r != 16'hffff) begin
                    opn_ms_r <= opn_ms_r + 16'h1;
                end
                for (int p = 0; p < 3; p++) begin
                    if (cur[p] > peak_r[p]) begin
                        peak_r[p] <= cur[p]; // see RL1
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Wear accumulators and alarm
    // ------------------------------------------------------------
    logic alarm_set;
    logic alarm_drop;
    logic clr_evt_r;
    logic fail_evt;
    always_comb begin
        alarm_set = 1'b0;
        alarm_drop = 1'b1;
        for (int p = 0; p < 3; p++) begin
            alarm_set = alarm_set || acc_r[p] >= {8'h0, alarm_lvl_r};
            alarm_drop = alarm_drop && acc_r[p] < {8'h0, drop_lvl_r};
        end
    end

    // Clear beats preload, preload beats an opening in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < 3; p++) begin
                acc_r[p] <= '0;
            end
        end else if (ce) begin
            for (int p = 0; p < 3; p++) begin
                if (wear_sum_clear_cmd) begin
                    acc_r[p] <= '0; // see RL14
                end else if (wear_sum_load_cmd && wear_sum_load_sel[p]) begin
                    acc_r[p] <= wear_sum_load_value; // see RL8, RL9
                end else if (add_r) begin
                    acc_r[p] <= sat_add(acc_r[p], wear_term(cap_r[p], ratio_s_r, time_r)); // see RL4
                end
            end
        end
    end

    // Alarm with hysteresis; set dominates if both levels overlap
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wear_sum_alarm <= 1'b0;
            wear_sum_alarm_evt <= 1'b0;
            clr_evt_r <= 1'b0;
        end else if (ce) begin
            wear_sum_alarm_evt <= alarm_set && !wear_sum_alarm; // see RL7
            clr_evt_r <= wear_sum_clear_cmd; // see RL14
            if (alarm_set) begin
                wear_sum_alarm <= 1'b1; // see RL7
            end else if (alarm_drop) begin
                wear_sum_alarm <= 1'b0;
            end
        end
    end
    assign wear_sum_clear_evt = clr_evt_r;
    assign fail_evt = st_cap_r == BWM_TRACK && open_fail && !open_rise && !cmd;

    // ------------------------------------------------------------
    // Operation window and recloser lockout
    // ------------------------------------------------------------
    logic [TS_W-1:0] ts_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [TS_W-1:0] age;
    logic pop;
    logic full;
    logic exc_q_r;
    assign age = now_r - ts_r[rp_r];
    assign pop = cnt_r != '0 && age >= WIN_C;
    assign full = cnt_r == DEPTH_C;

    // Timestamp ring; when full the oldest stamp is overwritten
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (open_rise) begin
                wp_r <= ptr_inc(wp_r); // see RL15
            end
            if (pop || (open_rise && full)) begin
                rp_r <= ptr_inc(rp_r); // see RL15
            end
            if (open_rise && !pop && !full) begin
                cnt_r <= cnt_r + (PW+1)'(1);
            end else if (pop && !open_rise) begin
                cnt_r <= cnt_r - (PW+1)'(1);
            end
        end
    end

    // Stamp storage holds no reset to stay a plain memory
    always_ff @(posedge mclk) begin
        if (ce && open_rise) begin
            ts_r[wp_r] <= now_r;
        end
    end

    // Lockout set on the flag's rise; a same-cycle manual close loses
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            excessive_trip_count_flag <= 1'b0;
            exc_q_r <= 1'b0;
            reclose_lockout <= 1'b0;
        end else if (ce) begin
            excessive_trip_count_flag <= cnt_r >= {1'b0, thr_r}; // see RL10
            exc_q_r <= excessive_trip_count_flag;
            if (excessive_trip_count_flag && !exc_q_r) begin
                reclose_lockout <= 1'b1; // see RL11
            end else if (manual_close_cmd) begin
                reclose_lockout <= 1'b0; // see RL12
            end
        end
    end

    assign ev[`BWM_ST_ALARM] = alarm_set && !wear_sum_alarm;
    assign ev[`BWM_ST_EXCESS] = excessive_trip_count_flag && !exc_q_r;
    assign ev[`BWM_ST_CLEAR] = wear_sum_clear_cmd;
    assign ev[`BWM_ST_OPEN] = open_rise;
    assign ev[`BWM_ST_FAIL] = fail_evt;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_open;
        open_rise && ce;
    endsequence
    sequence s_track_fail;
        ce && fail_evt;
    endsequence

    a_peak_follow: assert property (@(posedge mclk) disable iff (!resetn) // see RL1
        ce && st_cap_r == BWM_TRACK && !open_rise && !cmd && !open_fail && cur[0] > peak_r[0]
        |=> peak_r[0] == $past(cur[0]))
        else $error("peak missed a higher current");
    a_fail_zero: assert property (@(posedge mclk) disable iff (!resetn) // see RL2
        s_track_fail |=> cap_r[0] == '0 && cap_r[2] == '0 && st_cap_r == BWM_IDLE)
        else $error("open failure did not load zero");
    a_ext_nominal: assert property (@(posedge mclk) disable iff (!resetn) // see RL3
        s_open ##0 !meas_ok[1] |=> cap_r[1] == $past(inom_r))
        else $error("unmeasured phase not nominal");
    a_open_adds: assert property (@(posedge mclk) disable iff (!resetn) // see RL4
        s_open ##1 (ce && !wear_sum_clear_cmd && !wear_sum_load_cmd)
        |=> acc_r[0] == sat_add($past(acc_r[0]), wear_term($past(cap_r[0]),
            $past(ratio_s_r), $past(time_r))))
        else $error("opening not accumulated");
    a_ratio_sample: assert property (@(posedge mclk) disable iff (!resetn) // see RL5
        s_open |=> add_r && ratio_s_r == $past(ratio_r))
        else $error("operands not sampled at opening");
    a_manual_time: assert property (@(posedge mclk) disable iff (!resetn) // see RL6
        s_open ##0 (st_cap_r == BWM_IDLE || man_r) |=> time_r == 16'(`BWM_MAN_MS))
        else $error("manual opening time not fixed");
    a_alarm_set: assert property (@(posedge mclk) disable iff (!resetn) // see RL7
        ce && acc_r[2] >= {8'h0, alarm_lvl_r} |=> wear_sum_alarm)
        else $error("alarm level reached without alarm");
    a_preload_val: assert property (@(posedge mclk) disable iff (!resetn) // see RL8
        ce && wear_sum_load_cmd && wear_sum_load_sel[0] && !wear_sum_clear_cmd
        |=> acc_r[0] == $past(wear_sum_load_value))
        else $error("preload not taken");
    a_excess_cnt: assert property (@(posedge mclk) disable iff (!resetn) // see RL10
        ce && cnt_r >= {1'b0, thr_r} |=> excessive_trip_count_flag)
        else $error("excess flag missing");
    a_excess_lock: assert property (@(posedge mclk) disable iff (!resetn) // see RL11
        ce && $rose(excessive_trip_count_flag) |=> reclose_lockout)
        else $error("excess flag did not lock out");
    a_lock_holds: assert property (@(posedge mclk) disable iff (!resetn) // see RL12
        reclose_lockout && !manual_close_cmd |=> reclose_lockout)
        else $error("lockout left without manual close");
    a_level_range: assert property (@(posedge mclk) disable iff (!resetn) // see RL13
        alarm_lvl_r <= `BWM_LVL_MAX && drop_lvl_r <= `BWM_LVL_MAX)
        else $error("level setting out of range");
    a_clear_sum: assert property (@(posedge mclk) disable iff (!resetn) // see RL14
        ce && wear_sum_clear_cmd |=> acc_r[1] == '0 && wear_sum_clear_evt)
        else $error("clear not applied or reported");
    a_window_age: assert property (@(posedge mclk) disable iff (!resetn) // see RL15
        cnt_r != '0 |-> age <= WIN_C)
        else $error("stale opening still counted");
    a_bus_wait: assert property (@(posedge mclk) disable iff (!resetn)
        ce && avs_waitrequest ##1 ce |-> !avs_waitrequest)
        else $error("waitrequest held more than one cycle");
endmodule

// file: include/bwm_params.svh
`ifndef BWM_PARAMS_SVH
`define BWM_PARAMS_SVH
// How it works
// RL1 - Each phase keeps the peak current seen from a trip command to opening.
// RL2 - Every trip or manual open restarts capture; open failure loads zero.
// RL3 - Uncommanded openings capture on breaker-open rise, nominal if unmeasured.
// RL4 - Each opening adds (current times ratio) squared times opening time.
// RL5 - Current, ratio and opening time are sampled at the opening edge.
// RL6 - Manual openings capture on the open edge with a fixed 20 ms time.
// RL7 - Reaching the alarm level raises the wear alarm and logs an event.
// RL8 - The running sum can be preloaded; later openings add on top.
// RL9 - The sum is changed only by a logic command, never by settings.
// RL10 - Excess flag rises when openings within 30 minutes reach the threshold.
// RL11 - The excess flag locks out the recloser and inhibits further shots.
// RL12 - That lockout clears only on manual close or power loss.
// RL13 - Alarm and dropout levels span 0 to 99,999.99 in 0.01 steps.
// RL14 - The clear input zeroes the sum and is reported as output and event.
// RL15 - Openings are timestamped; those younger than 30 minutes are counted.

// Register byte offsets
`define BWM_REG_CTRL 8'h00
`define BWM_REG_STATUS 8'h04
`define BWM_REG_MASK 8'h08
`define BWM_REG_ALARM 8'h0c
`define BWM_REG_DROP 8'h10
`define BWM_REG_RATIO 8'h14
`define BWM_REG_INOM 8'h18
`define BWM_REG_OPCNT 8'h1c
`define BWM_REG_ACC0 8'h20
`define BWM_REG_CAP0 8'h2c

// Status bit positions
`define BWM_ST_ALARM 0
`define BWM_ST_EXCESS 1
`define BWM_ST_CLEAR 2
`define BWM_ST_OPEN 3
`define BWM_ST_FAIL 4
`define BWM_ST_W 5

// Reset values and ranges
`define BWM_THR_RST 7'h28
`define BWM_THR_MAX 7'h64
`define BWM_ALARM_RST 24'h98967f
`define BWM_DROP_RST 24'h000000
`define BWM_LVL_MAX 24'h98967f
`define BWM_RATIO_RST 16'h0001
`define BWM_INOM_RST 16'h01f4

// Timing
`define BWM_CLK_NS 100
`define BWM_MS_NS 1000000
`define BWM_MS_PER_S 1000
`define BWM_WIN_MIN 30
`define BWM_MAN_MS 20
`define BWM_TRIP_MAX 100

// Scale from (0.01 A)^2 * ms to 0.01 kA^2s
`define BWM_TERM_DIV 80'd100000000000
`endif

// file: include/bwm_pkg.sv
package bwm_pkg;
    // Capture sequencer
    typedef enum logic [0:0] {
        BWM_IDLE,
        BWM_TRACK
    } bwm_cap_t;
    typedef logic [15:0] bwm_cur_t;
endpackage

// file: test/bwm_brk_model.sv
`timescale 1ns/1ps
// ----
// Breaker: acts three cycles after a command
// ----
module bwm_brk_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cmd,
    input wire logic fail_en,
    input wire logic ext_open,
    input wire logic close_req,
    output logic brk_open,
    output logic open_fail
);
    logic [1:0] cnt_r;
    // Delay gives the relay a real tracking window
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 2'h0;
            brk_open <= 1'b0;
            open_fail <= 1'b0;
        end else begin
            open_fail <= (cnt_r == 2'h1) && fail_en;
            if (cmd) begin
                cnt_r <= 2'h3;
            end else if (cnt_r != 2'h0) begin
                cnt_r <= cnt_r - 2'h1;
            end
            if (close_req) begin
                brk_open <= 1'b0;
            end else if (ext_open || (cnt_r == 2'h1 && !fail_en)) begin
                brk_open <= 1'b1;
            end
        end
    end
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0, resetn = 1'b0, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, lfsr = 32'hbeb5;
    logic [31:0] wear_sum_load_value = 32'h0;
    logic [15:0] cur_a = 16'h0, cur_b = 16'h0, cur_c = 16'h0;
    logic [2:0] meas_ok = 3'h5, wear_sum_load_sel = 3'h0;
    logic trip_cmd = 1'b0, man_open_cmd = 1'b0, manual_close_cmd = 1'b0, open_fail, brk_open;
    logic wear_sum_clear_cmd = 1'b0, wear_sum_load_cmd = 1'b0;
    logic fail_en = 1'b0, ext_open = 1'b0, close_req = 1'b0;
    logic avs_waitrequest, wear_sum_alarm, wear_sum_alarm_evt, wear_sum_clear_evt;
    logic excessive_trip_count_flag, reclose_lockout, irq;
    logic [63:0] acc, r;
    int fail_count = 0, samples_checked = 0, evt_n = 0;

    // 100 ns period
    always #50 mclk = ~mclk;

    // Short tick counts and a 20 second window keep window expiry within reach
    bwm_top #(.MS_CYC(4), .MS_PER_S(4), .WIN_S(20)) dut_u (.mclk, .resetn, .ce,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .cur_a, .cur_b, .cur_c, .meas_ok, .trip_cmd, .man_open_cmd,
        .open_fail, .brk_open, .manual_close_cmd, .wear_sum_clear_cmd,
        .wear_sum_load_cmd, .wear_sum_load_sel, .wear_sum_load_value, .wear_sum_alarm,
        .wear_sum_alarm_evt, .wear_sum_clear_evt, .excessive_trip_count_flag,
        .reclose_lockout, .irq);
    bwm_brk_model brk_u (.mclk, .resetn, .cmd(trip_cmd || man_open_cmd), .fail_en, .ext_open,
        .close_req, .brk_open, .open_fail);

    // Alarm event pulses, seen at the edge that ends them
    always @(posedge mclk) begin
        if (wear_sum_alarm_evt === 1'b1) evt_n++;
    end

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Wear term for a 20 ms opening, fraction truncated
    function automatic logic [63:0] wterm(input logic [63:0] c);
        return (c * r) * (c * r) * 64'd20 / 64'd100000000000;
    endfunction
    task summarize;
        if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            fail_count++;
        end
    endtask
    // Holds the request until waitrequest is low at a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 50) fail_count++;
    endtask
    task rc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    // One opening: 0 manual, 1 external, 2 relay trip with a one-step peak
    task op(input logic [1:0] k);
        @(posedge mclk);
        lfsr = nxt(lfsr);
        cur_a <= {3'h1, lfsr[12:0]};
        cur_b <= lfsr[31:16];
        cur_c <= lfsr[15:0];
        man_open_cmd <= (k == 2'h0);
        ext_open <= (k == 2'h1);
        trip_cmd <= (k == 2'h2);
        @(posedge mclk);
        man_open_cmd <= 1'b0;
        ext_open <= 1'b0;
        trip_cmd <= 1'b0;
        cur_a <= cur_a + {15'h0, k[1]};
        @(posedge mclk);
        cur_a <= cur_a - {15'h0, k[1]};
        repeat (9) @(posedge mclk);
        close_req <= 1'b1;
        @(posedge mclk);
        close_req <= 1'b0;
        @(negedge mclk);
    endtask

    // Cut a hang short
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        summarize;
    end

    // ----
    // Main sequence
    // ----
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        rc("ctrl", 8'h00, 32'h28);
        rc("alarm", 8'h0c, 32'h98967f);
        rc("drop", 8'h10, 32'h0);
        rc("inom", 8'h18, 32'h1f4);
        rc("unmapped", 8'h40, 32'h0);
        bus(1'b1, 8'h0c, 32'h989680);
        rc("alarm", 8'h0c, 32'h98967f);
        lfsr = nxt(lfsr);
        r = {55'h0, 1'b1, lfsr[7:0]};
        bus(1'b1, 8'h14, r[31:0]);
        op(2'h0);
        acc = wterm(cur_a);
        rc("cap_a", 8'h2c, {16'h0, cur_a});
        rc("cap_b", 8'h30, 32'h1f4);
        rc("acc_a", 8'h20, acc[31:0]);
        op(2'h1);
        acc = acc + wterm(cur_a);
        rc("acc_a", 8'h20, acc[31:0]);
        @(posedge mclk);
        wear_sum_load_sel <= 3'h7;
        wear_sum_load_value <= 32'h4d2;
        wear_sum_load_cmd <= 1'b1;
        @(posedge mclk);
        wear_sum_load_cmd <= 1'b0;
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b1, 8'h0c, 32'h4d3);
        @(negedge mclk);
        chk("alarm", 32'h0, {31'h0, wear_sum_alarm});
        op(2'h0);
        acc = 64'h4d2 + wterm(cur_a);
        rc("acc_a", 8'h20, acc[31:0]);
        chk("alarm", 32'h1, {31'h0, wear_sum_alarm});
        chk("alarm_evt", 32'h1, evt_n);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, 8'h04, 32'h1);
        @(negedge mclk);
        chk("irq", 32'h0, {31'h0, irq});
        @(posedge mclk);
        wear_sum_clear_cmd <= 1'b1;
        @(posedge mclk);
        wear_sum_clear_cmd <= 1'b0;
        @(negedge mclk);
        chk("clear_evt", 32'h1, {31'h0, wear_sum_clear_evt});
        rc("acc_a", 8'h20, 32'h0);
        op(2'h2);
        rc("cap_a", 8'h2c, {16'h0, cur_a + 16'h1});
        fail_en <= 1'b1;
        op(2'h0);
        fail_en <= 1'b0;
        rc("cap_a", 8'h2c, 32'h0);
        repeat (400) @(posedge mclk);
        bus(1'b1, 8'h00, 32'h3);
        op(2'h0);
        op(2'h0);
        chk("excess", 32'h0, {31'h0, excessive_trip_count_flag});
        op(2'h0);
        chk("excess", 32'h1, {31'h0, excessive_trip_count_flag});
        rc("opcnt", 8'h1c, 32'h3);
        chk("lockout", 32'h1, {31'h0, reclose_lockout});
        @(posedge mclk);
        manual_close_cmd <= 1'b1;
        @(posedge mclk);
        manual_close_cmd <= 1'b0;
        @(negedge mclk);
        chk("lockout", 32'h0, {31'h0, reclose_lockout});
        summarize;
    end
endmodule
